/* core/audio_clock_divider_config.sv */
// What this block does
// - DAC clock divides source by field plus one
// - Charge-pump clock divides source by field plus one
// - Oversampling clock divides source by field plus one
// - Master bit clock divides master clock
// - Master frame clock divides bit clock
// - Interpolation bit selects 8x or 16x
// - Speed class codes 011, 100, 111
// - Auto-set disable bit, zero enables auto-set
`include "audio_clock_regs.svh"

module audio_clock_divider_config
   import audio_clock_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Register port
   input  reg_req_t        reg_req,
   output logic [7:0]      reg_rdata,
   output logic            reg_rvalid,
   // Clock pins
   input  wire logic       source_clk_pin,
   input  wire logic       mclk_pin,
   input  wire logic       frame_clk_pin,
   // Serial port mode
   input  wire logic       master_mode,
   // Divided internal clocks
   output logic            converter_clk,
   output logic            converter_tick,
   output logic            charge_pump_clk,
   output logic            charge_pump_tick,
   output logic            oversampling_clock,
   output logic            oversampling_tick,
   // Master-mode serial clocks
   output logic            master_bit_clk,
   output logic            master_frame_clk,
   output logic            master_clk_oe,
   // Settings in effect
   output logic            interpolation_depth_select,
   output logic            autoset_active,
   output clock_settings_t active_settings
);

   localparam int NUM_PINS = 3;
   localparam int PIN_SRC  = 0;
   localparam int PIN_MCLK = 1;
   localparam int PIN_FRM  = 2;

   // Software-written fields
   logic [6:0] converter_divider_value;
   logic [6:0] charge_pump_divider_value;
   logic [6:0] oversample_divider_value;
   logic [6:0] master_bit_clock_divider;
   logic [7:0] master_frame_clock_divider;
   logic       interp_field;
   logic [2:0] sample_rate_class;
   logic       autoset_disable;

   // Pin synchronisers and edge detection
   logic [NUM_PINS-1:0] pin_raw;
   logic [NUM_PINS-1:0] pin_meta;
   logic [NUM_PINS-1:0] pin_sync;
   logic [NUM_PINS-1:0] pin_prev;
   logic [NUM_PINS-1:0] pin_rise;

   assign pin_raw = {frame_clk_pin, mclk_pin, source_clk_pin};

   // Pins come from other clocks, so two flops before any logic reads them
   generate
      for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin_sync
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               pin_meta[i] <= 1'b0;
               pin_sync[i] <= 1'b0;
               pin_prev[i] <= 1'b0;
            end else begin
               pin_meta[i] <= pin_raw[i];
               pin_sync[i] <= pin_meta[i];
               pin_prev[i] <= pin_sync[i];
            end
         end
         assign pin_rise[i] = pin_sync[i] & ~pin_prev[i];
      end
   endgenerate

   // Address decode
   logic hit_dac;
   logic hit_ncp;
   logic hit_osr;
   logic hit_bclk;
   logic hit_fclk;
   logic hit_interp;
   logic hit_autoset;
   logic hit_any;

   assign hit_dac     = reg_req.addr == `REG_DAC_DIV;
   assign hit_ncp     = reg_req.addr == `REG_NCP_DIV;
   assign hit_osr     = reg_req.addr == `REG_OSR_DIV;
   assign hit_bclk    = reg_req.addr == `REG_BCLK_DIV;
   assign hit_fclk    = reg_req.addr == `REG_FCLK_DIV;
   assign hit_interp  = reg_req.addr == `REG_INTERP_RATE;
   assign hit_autoset = reg_req.addr == `REG_AUTOSET;
   assign hit_any     = hit_dac | hit_ncp | hit_osr | hit_bclk | hit_fclk | hit_interp | hit_autoset;

   // Register writes; unmapped offsets and reserved bits are dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         converter_divider_value    <= `DAC_DIV_RST;
         charge_pump_divider_value  <= `NCP_DIV_RST;
         oversample_divider_value   <= `OSR_DIV_RST;
         master_bit_clock_divider   <= `BCLK_DIV_RST;
         master_frame_clock_divider <= `FCLK_DIV_RST;
         interp_field               <= `INTERP_RST;
         sample_rate_class          <= `RATE_RST;
         autoset_disable            <= `AUTOSET_DIS_RST;
      end else if (reg_req.write) begin
         if (hit_dac) begin
            converter_divider_value <= reg_req.wdata[`DIV7_MSB:`DIV7_LSB];
         end
         if (hit_ncp) begin
            charge_pump_divider_value <= reg_req.wdata[`DIV7_MSB:`DIV7_LSB];
         end
         if (hit_osr) begin
            oversample_divider_value <= reg_req.wdata[`DIV7_MSB:`DIV7_LSB];
         end
         if (hit_bclk) begin
            master_bit_clock_divider <= reg_req.wdata[`DIV7_MSB:`DIV7_LSB];
         end
         if (hit_fclk) begin
            master_frame_clock_divider <= reg_req.wdata[`DIV8_MSB:`DIV8_LSB];
         end
         if (hit_interp) begin
            interp_field      <= reg_req.wdata[`INTERP_BIT];
            // Reserved codes are stored as written; keeping them out is up to software
            sample_rate_class <= reg_req.wdata[`RATE_MSB:`RATE_LSB];
         end
         if (hit_autoset) begin
            autoset_disable <= reg_req.wdata[`AUTOSET_DIS_BIT];
         end
      end
   end

   // Read mux; reserved bits and unmapped offsets read as zero
   logic [7:0] next_rdata;
   logic [7:0] rd_dac;
   logic [7:0] rd_ncp;
   logic [7:0] rd_osr;
   logic [7:0] rd_bclk;
   logic [7:0] rd_interp;
   logic [7:0] rd_autoset;

   assign rd_dac     = {1'b0, converter_divider_value};
   assign rd_ncp     = {1'b0, charge_pump_divider_value};
   assign rd_osr     = {1'b0, oversample_divider_value};
   assign rd_bclk    = {1'b0, master_bit_clock_divider};
   assign rd_interp  = {3'h0, interp_field, 1'b0, sample_rate_class};
   assign rd_autoset = {6'h00, autoset_disable, 1'b0};
   assign next_rdata = hit_dac     ? rd_dac :
                       hit_ncp     ? rd_ncp :
                       hit_osr     ? rd_osr :
                       hit_bclk    ? rd_bclk :
                       hit_fclk    ? master_frame_clock_divider :
                       hit_interp  ? rd_interp :
                       hit_autoset ? rd_autoset : 8'h00;

   // Read data is registered, valid the cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_req.read;
         if (reg_req.read) begin
            reg_rdata <= hit_any ? next_rdata : 8'h00;
         end
      end
   end

   // Frame-period measurement against the incoming frame clock
   measure_state_t meas_state;
   logic [15:0]    src_count;
   logic [15:0]    clk_count;
   logic [15:0]    src_ticks_per_frame;
   logic [15:0]    clk_per_frame;
   logic           measure_valid;
   logic           frame_edge;
   logic           clk_count_full;
   logic [15:0]    next_src_count;

   assign frame_edge     = pin_rise[PIN_FRM];
   assign clk_count_full = clk_count == 16'hffff;
   // Saturate rather than wrap so a very fast source cannot alias to a slow one
   assign next_src_count = (pin_rise[PIN_SRC] && src_count != 16'hffff) ? src_count + 16'h0001 : src_count;

   // A stalled frame clock drops back to idle and the last auto result is kept
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meas_state          <= MEAS_IDLE;
         src_count           <= 16'h0000;
         clk_count           <= 16'h0000;
         src_ticks_per_frame <= 16'h0000;
         clk_per_frame       <= 16'h0000;
         measure_valid       <= 1'b0;
      end else begin
         measure_valid <= 1'b0;
         unique case (meas_state)
            MEAS_IDLE: begin
               src_count <= 16'h0000;
               clk_count <= 16'h0000;
               if (frame_edge) begin
                  meas_state <= MEAS_RUN;
               end
            end
            MEAS_RUN: begin
               if (frame_edge) begin
                  src_ticks_per_frame <= next_src_count;
                  clk_per_frame       <= clk_count + 16'h0001;
                  measure_valid       <= 1'b1;
                  src_count           <= 16'h0000;
                  clk_count           <= 16'h0000;
               end else if (clk_count_full) begin
                  meas_state <= MEAS_IDLE;
               end else begin
                  src_count <= next_src_count;
                  clk_count <= clk_count + 16'h0001;
               end
            end
         endcase
      end
   end

   // Auto-set computation
   clock_settings_t auto_settings;
   clock_settings_t manual_settings;

   autoset_engine u_autoset_engine (
      .clk                 (clk),
      .rst_n               (rst_n),
      .measure_valid       (measure_valid),
      .src_ticks_per_frame (src_ticks_per_frame),
      .clk_per_frame       (clk_per_frame),
      .interp_16x          (interp_field),
      .auto_settings       (auto_settings)
   );

   // Auto-set overrides the DAC, charge-pump and oversampling dividers and speed class, not the interpolation depth
   assign manual_settings = '{converter_divider_value, charge_pump_divider_value,
                              oversample_divider_value, sample_rate_class};
   assign autoset_active             = ~autoset_disable;
   assign active_settings            = autoset_active ? auto_settings : manual_settings;
   assign interpolation_depth_select = interp_field;

   // Source clock dividers: DAC, charge pump, oversampling
   localparam int NUM_SRC_DIV = 3;
   logic [NUM_SRC_DIV-1:0][6:0] src_div_value;
   logic [NUM_SRC_DIV-1:0]      src_div_clk;
   logic [NUM_SRC_DIV-1:0]      src_div_tick;

   assign src_div_value = {active_settings.osr_div, active_settings.ncp_div, active_settings.dac_div};

   generate
      for (genvar d = 0; d < NUM_SRC_DIV; d++) begin : g_src_div
         clock_divider #(
            .WIDTH (7)
         ) u_src_div (
            .clk       (clk),
            .rst_n     (rst_n),
            .enable    (1'b1),
            .src_tick  (pin_rise[PIN_SRC]),
            .src_level (pin_sync[PIN_SRC]),
            .div_value (src_div_value[d]),
            .div_clk   (src_div_clk[d]),
            .div_tick  (src_div_tick[d])
         );
      end
   endgenerate

   assign converter_clk      = src_div_clk[0];
   assign converter_tick     = src_div_tick[0];
   assign charge_pump_clk    = src_div_clk[1];
   assign charge_pump_tick   = src_div_tick[1];
   assign oversampling_clock = src_div_clk[2];
   assign oversampling_tick  = src_div_tick[2];

   // Master mode: bit clock from master clock, frame clock from bit clock
   logic bit_tick;

   clock_divider #(
      .WIDTH (7)
   ) u_bit_div (
      .clk       (clk),
      .rst_n     (rst_n),
      .enable    (master_mode),
      .src_tick  (pin_rise[PIN_MCLK]),
      .src_level (pin_sync[PIN_MCLK]),
      .div_value (master_bit_clock_divider),
      .div_clk   (master_bit_clk),
      .div_tick  (bit_tick)
   );

   // The frame divider counts bit-clock wraps, one cycle behind the bit clock
   clock_divider #(
      .WIDTH (8)
   ) u_frame_div (
      .clk       (clk),
      .rst_n     (rst_n),
      .enable    (master_mode),
      .src_tick  (bit_tick),
      .src_level (master_bit_clk),
      .div_value (master_frame_clock_divider),
      .div_clk   (master_frame_clk),
      .div_tick  ()
   );

   // Drive the serial clock pins only as master
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         master_clk_oe <= 1'b0;
      end else begin
         master_clk_oe <= master_mode;
      end
   end

endmodule // audio_clock_divider_config

/* core/audio_clock_pkg.sv */
package audio_clock_pkg;

   // One register port request, valid for one cycle
   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Divider and speed-class settings in effect
   typedef struct packed {
      logic [6:0] dac_div;
      logic [6:0] ncp_div;
      logic [6:0] osr_div;
      logic [2:0] rate_class;
   } clock_settings_t;

   // Frame-period measurement
   typedef enum logic [0:0] {MEAS_IDLE, MEAS_RUN} measure_state_t;

endpackage

/* core/audio_clock_regs.svh */
`ifndef AUDIO_CLOCK_REGS_SVH
`define AUDIO_CLOCK_REGS_SVH

// Register offsets on the register port
`define REG_DAC_DIV        8'h1c
`define REG_NCP_DIV        8'h1d
`define REG_OSR_DIV        8'h1e
`define REG_BCLK_DIV       8'h20
`define REG_FCLK_DIV       8'h21
`define REG_INTERP_RATE    8'h22
`define REG_AUTOSET        8'h25

// Field positions
`define DIV7_MSB           6
`define DIV7_LSB           0
`define DIV8_MSB           7
`define DIV8_LSB           0
`define INTERP_BIT         4
`define RATE_MSB           2
`define RATE_LSB           0
`define AUTOSET_DIS_BIT    1

// Reset values
`define DAC_DIV_RST        7'h01
`define NCP_DIV_RST        7'h01
`define OSR_DIV_RST        7'h01
`define BCLK_DIV_RST       7'h00
`define FCLK_DIV_RST       8'h00
`define INTERP_RST         1'b0
`define RATE_RST           3'h4
`define AUTOSET_DIS_RST    1'b0

// Sample-rate class codes
`define RATE_48K           3'h3
`define RATE_96K           3'h4
`define RATE_32K           3'h7

// Timing: system clock and the frame rates that split the speed classes
`define CLK_HZ             20000000
`define FS_MID_HIGH_HZ     72000
`define FS_MID_LOW_HZ      40000

// Auto-set targets as right shifts of source ticks per frame
`define AUTO_DAC_SHIFT     7
`define AUTO_NCP_SHIFT     9
`define AUTO_OSR_SHIFT_8X  6
`define AUTO_OSR_SHIFT_16X 5

`endif

/* core/autoset_engine.sv */
`include "audio_clock_regs.svh"

module autoset_engine
   import audio_clock_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Measurement of one frame
   input  wire logic       measure_valid,
   input  wire logic [15:0] src_ticks_per_frame,
   input  wire logic [15:0] clk_per_frame,
   input  wire logic       interp_16x,
   // Computed settings
   output clock_settings_t auto_settings
);

   localparam logic [15:0] HIGH_RATE_CYCLES = 16'(`CLK_HZ / `FS_MID_HIGH_HZ);
   localparam logic [15:0] LOW_RATE_CYCLES  = 16'(`CLK_HZ / `FS_MID_LOW_HZ);

   // Divider field from the measured ratio, clamped to the 7-bit range
   function automatic logic [6:0] ratio_to_div(input logic [15:0] ticks, input int shift);
      logic [15:0] scaled;
      scaled = ticks >> shift;
      if (scaled == 16'h0000) begin
         return 7'h00;
      end else if (scaled > 16'h0080) begin
         return 7'h7f;
      end
      return 7'(scaled - 16'h0001);
   endfunction

   clock_settings_t next_settings;
   logic            is_high_rate;
   logic            is_low_rate;

   // Speed class from the frame period in system clocks
   assign is_high_rate = clk_per_frame < HIGH_RATE_CYCLES;
   assign is_low_rate  = clk_per_frame > LOW_RATE_CYCLES;
   assign next_settings.rate_class = is_high_rate ? `RATE_96K : (is_low_rate ? `RATE_32K : `RATE_48K);
   assign next_settings.dac_div = ratio_to_div(src_ticks_per_frame, `AUTO_DAC_SHIFT);
   assign next_settings.ncp_div = ratio_to_div(src_ticks_per_frame, `AUTO_NCP_SHIFT);
   assign next_settings.osr_div = ratio_to_div(src_ticks_per_frame,
                                               interp_16x ? `AUTO_OSR_SHIFT_16X : `AUTO_OSR_SHIFT_8X);

   // Hold the last result until a new frame is measured
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_settings <= '{`DAC_DIV_RST, `NCP_DIV_RST, `OSR_DIV_RST, `RATE_RST};
      end else if (measure_valid) begin
         auto_settings <= next_settings;
      end
   end

endmodule // autoset_engine

/* core/clock_divider.sv */
module clock_divider #(
   parameter int WIDTH = 7
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Source events and setting
   input  wire logic             enable,
   input  wire logic             src_tick,
   input  wire logic             src_level,
   input  wire logic [WIDTH-1:0] div_value,
   // Divided clock
   output logic                  div_clk,
   output logic                  div_tick
);

   logic [WIDTH-1:0] count;
   logic             wrap;
   logic [WIDTH-1:0] next_count;
   logic [WIDTH-1:0] shown_count;
   logic [WIDTH-1:0] half_point;

   // Wrap at the setting; a shrunk setting wraps at once instead of running to the top
   assign wrap        = count >= div_value;
   assign next_count  = wrap ? '0 : count + 1'b1;
   assign shown_count = src_tick ? next_count : count;
   assign half_point  = div_value >> 1;

   // Divide by div_value plus one source events
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count    <= '0;
         div_clk  <= 1'b0;
         div_tick <= 1'b0;
      end else if (!enable) begin
         count    <= '0;
         div_clk  <= 1'b0;
         div_tick <= 1'b0;
      end else begin
         div_tick <= src_tick & wrap;
         if (src_tick) begin
            count <= next_count;
         end
         // Divide by one passes the source level straight on
         div_clk <= (div_value == '0) ? src_level : (shown_count <= half_point);
      end
   end

endmodule // clock_divider

/* tb/audio_clock_asserts.sv */
`include "audio_clock_regs.svh"

module clock_rules_checker
   import audio_clock_pkg::*;
(
   // Clock and reset
   input wire logic      clk,
   input wire logic      rst_n,
   // Register port
   input reg_req_t       reg_req,
   input wire logic      reg_rvalid,
   // Serial clocks
   input wire logic      master_mode,
   input wire logic      master_bit_clk,
   input wire logic      master_frame_clk,
   // Settings in effect
   input wire logic      interpolation_depth_select,
   input wire logic      autoset_active,
   input clock_settings_t active_settings
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Write strobes per register, decoded from the write flag and address alone
   wire wr_dac = reg_req.write && reg_req.addr == `REG_DAC_DIV;
   wire wr_ncp = reg_req.write && reg_req.addr == `REG_NCP_DIV;
   wire wr_osr = reg_req.write && reg_req.addr == `REG_OSR_DIV;
   wire wr_ir  = reg_req.write && reg_req.addr == `REG_INTERP_RATE;
   wire wr_as  = reg_req.write && reg_req.addr == `REG_AUTOSET;

   a_manual_dac_div: assert property (!autoset_active && wr_dac |=> active_settings.dac_div == $past(reg_req.wdata[6:0]))
      else $error("dac divider not applied");
   a_manual_ncp_div: assert property (!autoset_active && wr_ncp |=> active_settings.ncp_div == $past(reg_req.wdata[6:0]))
      else $error("charge pump divider not applied");
   a_manual_osr_div: assert property (!autoset_active && wr_osr |=> active_settings.osr_div == $past(reg_req.wdata[6:0]))
      else $error("oversample divider not applied");
   a_slave_bit_idle: assert property (!master_mode [*2] |-> !master_bit_clk)
      else $error("bit clock runs outside master mode");
   a_slave_frame_idle: assert property (!master_mode [*3] |-> !master_frame_clk)
      else $error("frame clock runs outside master mode");
   a_interp_select: assert property (wr_ir |=> interpolation_depth_select == $past(reg_req.wdata[4]))
      else $error("interpolation select not applied");
   a_manual_rate: assert property (!autoset_active && wr_ir |=> active_settings.rate_class == $past(reg_req.wdata[2:0]))
      else $error("rate class not applied");
   a_autoset_bit: assert property (wr_as |=> autoset_active == !$past(reg_req.wdata[1]))
      else $error("autoset flag wrong");
   a_read_answer: assert property (reg_req.read |=> reg_rvalid ##1 !reg_rvalid || $past(reg_req.read))
      else $error("read answer missing");

   // Main scenarios reached
   c_manual_write: cover property (!autoset_active && wr_dac);
   c_frame_rise: cover property (master_mode && $rose(master_frame_clk));
   c_autoset_on: cover property (wr_as && !reg_req.wdata[1]);
endmodule // clock_rules_checker

bind audio_clock_divider_config clock_rules_checker chk_u (.clk, .rst_n, .reg_req, .reg_rvalid, .master_mode,
   .master_bit_clk, .master_frame_clk, .interpolation_depth_select, .autoset_active, .active_settings);

/* tb/tb_top.sv */
`include "audio_clock_regs.svh"

module tb_top
   import audio_clock_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic            clk, rst_n, reg_rvalid, master_mode;
   reg_req_t        reg_req;
   logic [7:0]      reg_rdata;
   logic            source_clk_pin, mclk_pin, frame_clk_pin;
   logic            converter_clk, converter_tick, charge_pump_clk, charge_pump_tick;
   logic            oversampling_clock, oversampling_tick, master_bit_clk, master_frame_clk, master_clk_oe;
   logic            interpolation_depth_select, autoset_active;
   clock_settings_t active_settings;
   integer          n_errors, tests_run, seed, i, p;
   integer          cnt [0:7];
   logic [9:0]      phase;
   logic            bit_prev, frame_prev, fast_frame;
   logic [2:0]      clk_prev;
   logic [7:0]      d;
   logic [7:0]      addrs [0:7] = '{8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h25};
   logic [7:0]      rstv [0:7]  = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};

   audio_clock_divider_config dut_u (.clk, .rst_n, .reg_req, .reg_rdata, .reg_rvalid, .source_clk_pin, .mclk_pin,
      .frame_clk_pin, .master_mode, .converter_clk, .converter_tick, .charge_pump_clk, .charge_pump_tick,
      .oversampling_clock, .oversampling_tick, .master_bit_clk, .master_frame_clk, .master_clk_oe,
      .interpolation_depth_select, .autoset_active, .active_settings);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Free-running pins: source and master clock every 8 cycles, frame every 512 (256 when fast)
   always @(posedge clk) begin
      phase          <= phase + 10'h001;
      source_clk_pin <= phase[2];
      mclk_pin       <= phase[2];
      frame_clk_pin  <= fast_frame ? phase[7] : phase[8];
   end

   // Running event counts; windows take differences, so no counter is ever cleared
   always @(posedge clk) begin
      bit_prev   <= master_bit_clk;
      frame_prev <= master_frame_clk;
      clk_prev   <= {oversampling_clock, charge_pump_clk, converter_clk};
      // Outputs may be unknown before the first reset edge, so counting waits for release
      if (rst_n) begin
         cnt[0] <= cnt[0] + converter_tick;
         cnt[1] <= cnt[1] + charge_pump_tick;
         cnt[2] <= cnt[2] + oversampling_tick;
         cnt[3] <= cnt[3] + (master_bit_clk & ~bit_prev);
         cnt[4] <= cnt[4] + (master_frame_clk & ~frame_prev);
         cnt[5] <= cnt[5] + (converter_clk & ~clk_prev[0]);
         cnt[6] <= cnt[6] + (charge_pump_clk & ~clk_prev[1]);
         cnt[7] <= cnt[7] + (oversampling_clock & ~clk_prev[2]);
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      reg_req <= '0;
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge clk);
      reg_req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      reg_req <= '0;
      // The answer stands for one cycle only, so look right after the taking edge
      #1;
      check("read valid", {31'h0, reg_rvalid}, 32'h1);
      check(name, {24'h0, reg_rdata}, {24'h0, exp});
   endtask

   // Writable bits of each register; unmapped places keep nothing
   function automatic logic [7:0] mask_of(input logic [7:0] a);
      case (a)
         8'h1c, 8'h1d, 8'h1e, 8'h20: mask_of = 8'h7f;
         8'h21: mask_of = 8'hff;
         8'h22: mask_of = 8'h17;
         8'h25: mask_of = 8'h02;
         default: mask_of = 8'h00;
      endcase
   endfunction

   // Ratios of powers of two keep every count exact over a 256-edge window
   function automatic logic [7:0] pw(input integer k);
      pw = (8'h01 << k) - 8'h01;
   endfunction

   task automatic div_run(input logic [6:0] dv, nv, ov, bv, input logic [7:0] fv);
      integer st [0:7];
      reg_write(`REG_AUTOSET, 8'h02);
      reg_write(`REG_DAC_DIV, {1'b0, dv});
      reg_write(`REG_NCP_DIV, {1'b0, nv});
      reg_write(`REG_OSR_DIV, {1'b0, ov});
      reg_write(`REG_BCLK_DIV, {1'b0, bv});
      reg_write(`REG_FCLK_DIV, fv);
      reg_write(`REG_INTERP_RATE, 8'h03);
      master_mode <= 1'b1;
      repeat (2048) @(posedge clk);
      while (phase !== 10'h000) @(posedge clk);
      st = cnt;
      repeat (2048) @(posedge clk);
      check("dac ticks", cnt[0] - st[0], 256 / (dv + 1));
      check("pump ticks", cnt[1] - st[1], 256 / (nv + 1));
      check("osr ticks", cnt[2] - st[2], 256 / (ov + 1));
      check("dac clock rises", cnt[5] - st[5], 256 / (dv + 1));
      check("pump clock rises", cnt[6] - st[6], 256 / (nv + 1));
      check("osr clock rises", cnt[7] - st[7], 256 / (ov + 1));
      check("pin enable", {31'h0, master_clk_oe}, 32'h1);
      check("bit rises", cnt[3] - st[3], 256 / (bv + 1));
      check("frame rises", cnt[4] - st[4], 256 / ((bv + 1) * (fv + 1)));
      check("manual settings", active_settings, {dv, nv, ov, 3'h3});
   endtask

   initial begin
      seed = 16874;
      n_errors = 0;
      tests_run = 0;
      phase = 10'h000;
      cnt = '{0, 0, 0, 0, 0, 0, 0, 0};
      fast_frame = 1'b0;
      rst_n = 1'b0;
      reg_req = '0;
      master_mode = 1'b0;
      source_clk_pin = 1'b0;
      mclk_pin = 1'b0;
      frame_clk_pin = 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      check("reset autoset", {31'h0, autoset_active}, 32'h1);
      check("reset settings", active_settings, {7'h01, 7'h01, 7'h01, 3'h4});
      for (i = 0; i < 8; i++) reg_read(addrs[i], rstv[i], "reset value");
      // Full ones first shows every reserved bit, then random data
      for (p = 0; p < 2; p++) begin
         for (i = 0; i < 8; i++) begin
            d = (p == 0) ? 8'hff : 8'($random(seed));
            reg_write(addrs[i], d);
            reg_read(addrs[i], d & mask_of(addrs[i]), "readback");
         end
      end
      div_run(7'h7f, 7'h00, 7'h3f, 7'h00, 8'hff);
      div_run(7'h00, 7'h01, 7'h03, 7'h07, 8'h1f);
      for (i = 0; i < 5; i++) begin
         div_run(pw($random(seed) & 7), pw($random(seed) & 7), pw($random(seed) & 7),
                 pw($random(seed) & 3), pw($random(seed) & 3));
      end
      // Auto-set: 64 source edges and 512 cycles per frame
      reg_write(`REG_DAC_DIV, 8'h55);
      reg_write(`REG_INTERP_RATE, 8'h03);
      reg_write(`REG_AUTOSET, 8'h00);
      master_mode <= 1'b0;
      repeat (1600) @(posedge clk);
      #1;
      check("auto settings 8x", active_settings, {7'h00, 7'h00, 7'h00, 3'h7});
      check("bit clock idle", {31'h0, master_bit_clk}, 32'h0);
      check("pin release", {31'h0, master_clk_oe}, 32'h0);
      reg_read(`REG_DAC_DIV, 8'h55, "dac field kept");
      reg_write(`REG_INTERP_RATE, 8'h13);
      repeat (1600) @(posedge clk);
      #1;
      check("interp 16x", {31'h0, interpolation_depth_select}, 32'h1);
      check("auto settings 16x", active_settings, {7'h00, 7'h00, 7'h01, 3'h7});
      // Shorter frames: 32 source edges and 256 cycles move the speed class to the high band
      fast_frame <= 1'b1;
      repeat (1600) @(posedge clk);
      #1;
      check("auto settings fast", active_settings, {7'h00, 7'h00, 7'h00, 3'h4});
      summarize();
   end

   // Hang guard, about twice the expected run
   initial begin
      repeat (80000) @(posedge clk);
      n_errors = n_errors + 1;
      summarize();
   end
endmodule // tb_top
